// file: iot_timing.sv
// iot_timing: pair-overlap timing controller for a word processor core
// assumes decoded instruction pairs arrive with valid/ready from the fetch unit
`timescale 1ns/1ps
`default_nettype none

module iot_timing
  import iot_pkg::*;
#(
  parameter int DUR_W = 10
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // pair from fetch
  input wire iot_pair_type pairIn,
  input wire logic pairValid,
  output logic pairReady,
  // mode
  input wire logic slaveMode,
  input wire logic storeCtrOp,
  input wire logic storeCharsOp,
  // issue status
  output logic execBusy,
  output logic execDone,
  output logic [DUR_W-1:0] lastDuration,
  output logic loadBaseEnable,
  output logic prefetchDiscard
);

  ////////////////////////////////////////////////////////////////////////////
  // duration arithmetic, all in tenths of a microsecond

  function automatic int modAdj(input iot_mod_type m, input logic [2:0] n, input logic drain);
    int r;
    r = 0;
    unique case (m)
      IOT_MOD_REG: r = 0;
      IOT_MOD_DIRECT: r = drain ? 0 : -ADJ_DIRECT_SAVE;
      IOT_MOD_REG_IND: r = ADJ_REG_IND * int'(n);
      IOT_MOD_IND_REG: r = ADJ_IND_REG * int'(n);
      IOT_MOD_IND_TALLY: r = ADJ_IND_TALLY * int'(n);
      default: r = 0;
    endcase
    return r;
  endfunction : modAdj

  function automatic int shiftAdj(input iot_instr_type i);
    int r;
    r = ADJ_SHIFT_CYCLE * (int'(i.shiftCycles) - SHIFT_MEAN_CYCLES);
    if (r > SHIFT_VAR_LIMIT) begin
      r = SHIFT_VAR_LIMIT;
    end
    if (r < -SHIFT_VAR_LIMIT) begin
      r = -SHIFT_VAR_LIMIT;
    end
    if (i.normUnnorm) begin
      r = r + ADJ_SHIFT_CYCLE * int'(i.normShifts > 3'(NORM_MAX_SHIFTS) ? 3'(NORM_MAX_SHIFTS) : i.normShifts);
      if (r > NORM_MAX_ADD) begin
        r = NORM_MAX_ADD;
      end
    end
    return r;
  endfunction : shiftAdj

  // drain wait scales with long operations queued, held inside 1.0..2.0 us
  function automatic int drainAdj(input logic [1:0] depth);
    int r;
    r = ADJ_DRAIN_MIN + 5 * int'(depth);
    if (r > ADJ_DRAIN_MAX) begin
      r = ADJ_DRAIN_MAX;
    end
    return r;
  endfunction : drainAdj

  ////////////////////////////////////////////////////////////////////////////
  // pipeline state

  typedef enum logic [1:0] {
    IOT_IDLE,
    IOT_RUN_EVEN,
    IOT_RUN_ODD
  } iot_state_type;

  iot_state_type state_ff, nxt_state;
  iot_pair_type pair_ff;
  logic [15:0] cycCnt_ff;
  logic [1:0] longDepth_ff;
  logic prevStore_ff;
  logic prevXfer_ff;
  logic hazard_ff;
  logic selfMod_ff;
  logic pairReady_ff, execBusy_ff, execDone_ff, loadBaseEnable_ff, prefetchDiscard_ff;
  logic [DUR_W-1:0] lastDuration_ff;

  iot_instr_type cur;
  logic curOdd;
  logic drainNow;
  int dur;
  logic [15:0] cycTarget;

  always_comb begin
    cur = (state_ff == IOT_RUN_ODD) ? pair_ff.odd : pair_ff.even;
    curOdd = (state_ff == IOT_RUN_ODD);
    drainNow = (longDepth_ff != 2'h0);
    dur = int'(cur.baseTime);
    if (cur.opClass == IOT_OP_STORE && storeCtrOp) begin
      dur = BASE_STORE_CTR;
    end
    if (cur.opClass == IOT_OP_STORE && storeCharsOp) begin
      dur = BASE_STORE_CHARS;
    end
    dur = dur + modAdj(cur.modType, cur.indirectCycles, drainNow);
    if (curOdd && hazard_ff) begin
      dur = dur + ADJ_INDEX_HAZ;
    end
    if (curOdd && selfMod_ff) begin
      dur = dur + ADJ_SELF_MOD;
    end
    if (cur.opClass == IOT_OP_XFER && curOdd) begin
      dur = dur + ADJ_XFER_ODD;
    end
    if (prevXfer_ff && curOdd) begin
      dur = dur + ADJ_TARGET_ODD;
    end
    if (drainNow && (cur.opClass == IOT_OP_XFER || (cur.opClass == IOT_OP_STORE && curOdd))) begin
      dur = dur + drainAdj(longDepth_ff);
    end else if (cur.opClass == IOT_OP_STORE) begin
      dur = curOdd ? dur + ADJ_STORE_PARITY : dur - ADJ_STORE_PARITY;
    end
    if (cur.opClass == IOT_OP_STORE && prevStore_ff) begin
      dur = dur - ADJ_STORE_CHAIN;
    end
    if (cur.opClass == IOT_OP_SHIFT || cur.opClass == IOT_OP_LONG) begin
      dur = dur + shiftAdj(cur);
    end
    if (dur < 1) begin
      dur = 1;
    end
    cycTarget = 16'(dur * CYC_PER_TENTH);
  end

  logic instrEnd;
  assign instrEnd = (state_ff != IOT_IDLE) && (cycCnt_ff + 16'h0001 >= cycTarget);

  ////////////////////////////////////////////////////////////////////////////
  // sequencing

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      IOT_IDLE: begin
        if (pairValid) begin
          nxt_state = pairIn.startOdd ? IOT_RUN_ODD : IOT_RUN_EVEN;
        end
      end
      IOT_RUN_EVEN: begin
        if (instrEnd) begin
          nxt_state = IOT_RUN_ODD;
        end
      end
      IOT_RUN_ODD: begin
        if (instrEnd) begin
          nxt_state = pairValid ? (pairIn.startOdd ? IOT_RUN_ODD : IOT_RUN_EVEN) : IOT_IDLE;
        end
      end
    endcase
  end

  logic takePair;
  assign takePair = pairValid && ((state_ff == IOT_IDLE) || (state_ff == IOT_RUN_ODD && instrEnd));

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_ff <= IOT_IDLE;
      pair_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (takePair) begin
        pair_ff <= pairIn; // next pair prefetched while odd one finishes
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || takePair || instrEnd) begin
      cycCnt_ff <= 16'h0000;
    end else if (state_ff != IOT_IDLE) begin
      cycCnt_ff <= cycCnt_ff + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // history carried between instructions

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      longDepth_ff <= 2'h0;
      prevStore_ff <= 1'b0;
      prevXfer_ff <= 1'b0;
    end else if (instrEnd) begin
      prevStore_ff <= (cur.opClass == IOT_OP_STORE);
      prevXfer_ff <= (cur.opClass == IOT_OP_XFER);
      if (cur.opClass == IOT_OP_LONG || cur.opClass == IOT_OP_SHIFT) begin
        longDepth_ff <= (longDepth_ff == 2'h3) ? 2'h3 : longDepth_ff + 2'h1;
      end else if (cur.opClass == IOT_OP_XFER || cur.opClass == IOT_OP_STORE) begin
        longDepth_ff <= 2'h0; // drained behind this instruction
      end
    end
  end

  // hazards raised by the even word against its odd partner
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hazard_ff <= 1'b0;
      selfMod_ff <= 1'b0;
    end else if (state_ff == IOT_RUN_EVEN && instrEnd) begin
      hazard_ff <= cur.writesIndex && pair_ff.odd.usesIndex
        && (cur.indexWritten == pair_ff.odd.indexUsed);
      selfMod_ff <= cur.writesNext;
    end else if (instrEnd) begin
      hazard_ff <= 1'b0;
      selfMod_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pairReady_ff <= 1'b1;
      execBusy_ff <= 1'b0;
      execDone_ff <= 1'b0;
      lastDuration_ff <= '0;
      loadBaseEnable_ff <= 1'b0;
      prefetchDiscard_ff <= 1'b0;
    end else begin
      pairReady_ff <= (nxt_state == IOT_IDLE);
      execBusy_ff <= (nxt_state != IOT_IDLE);
      execDone_ff <= instrEnd;
      prefetchDiscard_ff <= (state_ff == IOT_RUN_EVEN) && instrEnd && cur.writesNext;
      loadBaseEnable_ff <= instrEnd && (cur.opClass == IOT_OP_LOAD_BASE) && !slaveMode;
      if (instrEnd) begin
        lastDuration_ff <= DUR_W'(dur);
      end
    end
  end

  assign pairReady = pairReady_ff;
  assign execBusy = execBusy_ff;
  assign execDone = execDone_ff;
  assign lastDuration = lastDuration_ff;
  assign loadBaseEnable = loadBaseEnable_ff;
  assign prefetchDiscard = prefetchDiscard_ff;

endmodule : iot_timing
`default_nettype wire

// file: iot_pkg.sv
// iot_pkg: constants and types for the instruction overlap timing block
// assumes a 40 MHz system clock; times are held in tenths of a microsecond
package iot_pkg;

  // clock rate and derived cycles per 0.1 us
  localparam int CLK_MHZ = 40;
  localparam int TENTH_NS = 100;
  localparam int CYC_PER_TENTH = (TENTH_NS * CLK_MHZ) / 1000;

  // adjustments in tenths of a microsecond
  localparam int ADJ_DIRECT_SAVE = 5;
  localparam int ADJ_REG_IND = 11;
  localparam int ADJ_IND_REG = 17;
  localparam int ADJ_IND_TALLY = 25;
  localparam int ADJ_INDEX_HAZ = 8;
  localparam int ADJ_SELF_MOD = 17;
  localparam int ADJ_XFER_ODD = 5;
  localparam int ADJ_TARGET_ODD = 8;
  localparam int ADJ_DRAIN_MIN = 10;
  localparam int ADJ_DRAIN_MAX = 20;
  localparam int ADJ_STORE_PARITY = 5;
  localparam int ADJ_STORE_CHAIN = 5;
  localparam int ADJ_SHIFT_CYCLE = 2;
  localparam int SHIFT_MEAN_CYCLES = 5;
  localparam int SHIFT_VAR_LIMIT = 8;
  localparam int NORM_MAX_SHIFTS = 7;
  localparam int NORM_MAX_ADD = 15;

  // base times of the counter and character stores
  localparam int BASE_STORE_CTR = 29;
  localparam int BASE_STORE_CHARS = 25;

  // reset values
  localparam logic [1:0] PAIR_RESET = 2'h0;

  typedef enum logic [2:0] {
    IOT_MOD_REG,
    IOT_MOD_DIRECT,
    IOT_MOD_REG_IND,
    IOT_MOD_IND_REG,
    IOT_MOD_IND_TALLY
  } iot_mod_type;

  typedef enum logic [2:0] {
    IOT_OP_PLAIN,
    IOT_OP_STORE,
    IOT_OP_XFER,
    IOT_OP_LONG,
    IOT_OP_SHIFT,
    IOT_OP_LOAD_BASE
  } iot_class_type;

  // one decoded instruction as the fetch side hands it over
  typedef struct packed {
    logic [7:0] baseTime;
    iot_class_type opClass;
    iot_mod_type modType;
    logic [2:0] indirectCycles;
    logic [2:0] indexUsed;
    logic usesIndex;
    logic [2:0] indexWritten;
    logic writesIndex;
    logic writesNext;
    logic [3:0] shiftCycles;
    logic normUnnorm;
    logic [2:0] normShifts;
  } iot_instr_type;

  // one instruction pair as fetched from memory
  typedef struct packed {
    iot_instr_type even;
    iot_instr_type odd;
    logic startOdd;
  } iot_pair_type;

endpackage : iot_pkg

// file: iot_timing_sva.sv
// iot_timing_sva: port checks of the overlap timer
// assumes a bind onto iot_timing from the bench top file
`timescale 1ns/1ps
`default_nettype none
module iot_timing_sva
  import iot_pkg::*;
#(
  parameter int DUR_W = 10
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // fetch side
  input wire iot_pair_type pairIn,
  input wire logic pairValid,
  input wire logic pairReady,
  // mode
  input wire logic slaveMode,
  input wire logic storeCtrOp,
  input wire logic storeCharsOp,
  // status
  input wire logic execBusy,
  input wire logic execDone,
  input wire logic [DUR_W-1:0] lastDuration,
  input wire logic loadBaseEnable,
  input wire logic prefetchDiscard
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  sequence take_s;
    pairValid && pairReady && !execBusy;
  endsequence
  // shortest word is 0.1 us, so no done for four cycles
  sequence quiet_s;
    !execDone [*4];
  endsequence
  reset_idle_a: assert property ($fell(rst) |-> pairReady && !execBusy && !execDone)
    else $error("outputs not idle after reset");
  take_busy_a: assert property (take_s |=> execBusy)
    else $error("taken pair did not start");
  start_quiet_a: assert property (take_s |=> quiet_s)
    else $error("done too soon after start");
  done_pulse_a: assert property (execDone |=> !execDone)
    else $error("done longer than one cycle");
  done_busy_a: assert property (execDone |-> $past(execBusy))
    else $error("done without busy");
  dur_nonzero_a: assert property (execDone |-> lastDuration != '0)
    else $error("zero duration");
  dur_hold_a: assert property (!execDone |-> $stable(lastDuration))
    else $error("duration moved without done");
  base_slave_a: assert property (loadBaseEnable |-> execDone && !$past(slaveMode))
    else $error("base load enabled in slave mode");
  discard_done_a: assert property (prefetchDiscard |-> execDone)
    else $error("discard outside done");
endmodule : iot_timing_sva
`default_nettype wire

// file: iot_mem.sv
// iot_mem: memory side handing decoded pairs to the timer
// assumes the timer samples pairValid on rising clk_sys
`timescale 1ns/1ps
`default_nettype none
module iot_mem
  import iot_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // pair handover
  output var iot_pair_type pairIn,
  output var logic pairValid,
  input wire logic pairReady
);
  initial begin
    pairIn = '0;
    pairValid = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // gap makes a slow memory; released word shows the inverse
  task automatic send(input iot_pair_type p, input int gap);
    repeat (gap) @(posedge clk_sys);
    #1;
    pairIn = p;
    pairValid = 1'b1;
    do @(posedge clk_sys); while (pairReady !== 1'b1);
    #1;
    pairValid = 1'b0;
    pairIn = ~p;
  endtask : send
endmodule : iot_mem
`default_nettype wire

// file: tb.sv
// tb: self-checking bench for the overlap timer
// assumes one 40 MHz clock and pairs from iot_mem
`timescale 1ns/1ps
`default_nettype none
module tb;
  import iot_pkg::*;
  localparam int DUR_W = 10;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic slaveMode = 1'b0;
  logic storeCtrOp = 1'b0;
  logic storeCharsOp = 1'b0;
  iot_pair_type pairIn;
  logic pairValid, pairReady, execBusy, execDone, lbSeen, pdSeen, loadBaseEnable, prefetchDiscard;
  logic [DUR_W-1:0] lastDuration;
  int fail_count = 0;
  int checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  iot_mem iot_mem_i (.clk_sys(clk_sys), .pairIn(pairIn), .pairValid(pairValid), .pairReady(pairReady));
  iot_timing #(.DUR_W(DUR_W)) iot_timing_i (.clk_sys(clk_sys), .rst(rst), .pairIn(pairIn),
    .pairValid(pairValid), .pairReady(pairReady), .slaveMode(slaveMode), .storeCtrOp(storeCtrOp),
    .storeCharsOp(storeCharsOp), .execBusy(execBusy), .execDone(execDone), .lastDuration(lastDuration),
    .loadBaseEnable(loadBaseEnable), .prefetchDiscard(prefetchDiscard));
  ////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string n, input logic [DUR_W-1:0] e, input logic [DUR_W-1:0] s);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %0d seen %0d", n, e, s);
    end
  endtask : chk
  task automatic chkb(input string n, input logic e, input logic s);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %b seen %b", n, e, s);
    end
  endtask : chkb
  function automatic iot_instr_type mk(input int b, input iot_class_type c, input iot_mod_type m);
    mk = '0;
    mk.baseTime = b[7:0];
    mk.opClass = c;
    mk.modType = m;
    mk.shiftCycles = 4'h5;
  endfunction : mk
  // bounded wait; a lost done shows as a failed done check
  task automatic wdone;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (execDone !== 1'b1 && n < 400);
    chkb("done", 1'b1, execDone);
  endtask : wdone
  // fresh reset per pair keeps store and drain history known
  task automatic go(input iot_instr_type ev, input iot_instr_type od, input int gap, input int e0,
    input int e1);
    rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    iot_mem_i.send('{even: ev, odd: od, startOdd: 1'b0}, gap);
    wdone;
    lbSeen = loadBaseEnable;
    pdSeen = prefetchDiscard;
    chk("even", e0[DUR_W-1:0], lastDuration);
    chkb("busy_even", 1'b1, execBusy);
    wdone;
    chk("odd", e1[DUR_W-1:0], lastDuration);
    chkb("busy_odd", 1'b0, execBusy);
    chkb("ready", 1'b1, pairReady);
  endtask : go
  ////////////////////////////////////////////////////////////
  task automatic t_mod;
    go(mk(18, IOT_OP_PLAIN, IOT_MOD_REG), mk(18, IOT_OP_PLAIN, IOT_MOD_DIRECT), 0, 18, 13);
  endtask : t_mod
  task automatic t_ind;
    iot_instr_type a, b;
    a = mk(18, IOT_OP_PLAIN, IOT_MOD_REG_IND);
    b = mk(18, IOT_OP_PLAIN, IOT_MOD_IND_REG);
    a.indirectCycles = 3'h1;
    b.indirectCycles = 3'h2;
    go(a, b, 0, 29, 52);
    a = mk(18, IOT_OP_PLAIN, IOT_MOD_IND_TALLY);
    a.indirectCycles = 3'h1;
    go(a, mk(18, IOT_OP_PLAIN, IOT_MOD_REG), 0, 43, 18);
  endtask : t_ind
  task automatic t_haz;
    iot_instr_type a, b;
    a = mk(18, IOT_OP_PLAIN, IOT_MOD_REG);
    b = a;
    a.writesIndex = 1'b1;
    a.indexWritten = 3'h3;
    b.usesIndex = 1'b1;
    b.indexUsed = 3'h3;
    go(a, b, 0, 18, 26);
    b.indexUsed = 3'h2;
    go(a, b, 0, 18, 18);
    a = mk(18, IOT_OP_PLAIN, IOT_MOD_REG);
    a.writesNext = 1'b1;
    go(a, mk(18, IOT_OP_PLAIN, IOT_MOD_REG), 0, 18, 35);
    chkb("discard", 1'b1, pdSeen);
  endtask : t_haz
  task automatic t_xfer;
    go(mk(18, IOT_OP_PLAIN, IOT_MOD_REG), mk(10, IOT_OP_XFER, IOT_MOD_REG), 0, 18, 15);
    go(mk(10, IOT_OP_XFER, IOT_MOD_REG), mk(18, IOT_OP_PLAIN, IOT_MOD_REG), 0, 10, 26);
    go(mk(70, IOT_OP_LONG, IOT_MOD_REG), mk(25, IOT_OP_STORE, IOT_MOD_REG), 0, 70, 40);
    go(mk(70, IOT_OP_LONG, IOT_MOD_REG), mk(10, IOT_OP_XFER, IOT_MOD_REG), 0, 70, 30);
  endtask : t_xfer
  // transfer history survives idle, so an odd-entry pair pays the target penalty
  task automatic t_odd;
    go(mk(18, IOT_OP_PLAIN, IOT_MOD_REG), mk(10, IOT_OP_XFER, IOT_MOD_REG), 0, 18, 15);
    iot_mem_i.send('{even: mk(18, IOT_OP_XFER, IOT_MOD_REG), odd: mk(18, IOT_OP_PLAIN, IOT_MOD_REG), startOdd: 1'b1}, 0);
    wdone;
    chk("target", DUR_W'(26), lastDuration);
    chkb("busy_target", 1'b0, execBusy);
  endtask : t_odd
  task automatic t_store;
    go(mk(25, IOT_OP_STORE, IOT_MOD_REG), mk(25, IOT_OP_STORE, IOT_MOD_REG), 0, 20, 25);
    storeCtrOp = 1'b1;
    go(mk(25, IOT_OP_STORE, IOT_MOD_REG), mk(18, IOT_OP_PLAIN, IOT_MOD_REG), 0, 24, 18);
    storeCtrOp = 1'b0;
    storeCharsOp = 1'b1;
    go(mk(30, IOT_OP_STORE, IOT_MOD_REG), mk(18, IOT_OP_PLAIN, IOT_MOD_REG), 0, 20, 18);
    storeCharsOp = 1'b0;
  endtask : t_store
  task automatic t_shift;
    iot_instr_type a, b;
    a = mk(18, IOT_OP_SHIFT, IOT_MOD_REG);
    b = a;
    a.shiftCycles = 4'h9;
    b.shiftCycles = 4'h0;
    go(a, b, 0, 26, 10);
    a = mk(18, IOT_OP_LONG, IOT_MOD_REG);
    a.normUnnorm = 1'b1;
    a.normShifts = 3'h7;
    go(a, mk(18, IOT_OP_PLAIN, IOT_MOD_DIRECT), 0, 32, 18);
  endtask : t_shift
  task automatic t_base;
    slaveMode = 1'b1;
    go(mk(18, IOT_OP_LOAD_BASE, IOT_MOD_REG), mk(18, IOT_OP_PLAIN, IOT_MOD_REG), 3, 18, 18);
    chkb("base_en", 1'b0, lbSeen);
    slaveMode = 1'b0;
    go(mk(18, IOT_OP_LOAD_BASE, IOT_MOD_REG), mk(18, IOT_OP_PLAIN, IOT_MOD_REG), 3, 18, 18);
    chkb("base_en", 1'b1, lbSeen);
  endtask : t_base
  initial begin
    t_mod;
    t_ind;
    t_haz;
    t_xfer;
    t_odd;
    t_store;
    t_shift;
    t_base;
    report_and_stop;
  end
  initial begin
    #400us;
    fail_count++;
    report_and_stop;
  end
endmodule : tb
bind iot_timing iot_timing_sva #(.DUR_W(DUR_W)) iot_timing_sva_i (.clk_sys(clk_sys), .rst(rst),
  .pairIn(pairIn), .pairValid(pairValid), .pairReady(pairReady), .slaveMode(slaveMode),
  .storeCtrOp(storeCtrOp), .storeCharsOp(storeCharsOp), .execBusy(execBusy), .execDone(execDone),
  .lastDuration(lastDuration), .loadBaseEnable(loadBaseEnable), .prefetchDiscard(prefetchDiscard));
`default_nettype wire
